// File: hw/acsp_port.sv
// Serial command port of the converter: link-side decode and master clock side
`default_nettype none
module acsp_port
  import acsp_pkg::*;
(
  // Master clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Serial pins
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  output logic CONV_DONE_N,
  // Conversion results
  input wire logic RESULT_STB,
  input wire logic [STATUS_FREE_W-1:0] STATUS_BITS,
  input wire logic [RESULT_W-1:0] CH_RESULTS,
  // Decoded commands
  output logic [SYS_N-1:0] SYS_CMD_P,
  output logic CONT_READ,
  // Register file access
  output logic [ADDR_W-1:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WE,
  input wire logic [7:0] REG_RDATA
);
  localparam int SYNC_MIN = 1;
  localparam int SYNC_MAX = 3;

  acsp_link_if lnk ();

  // Link side state
  logic ser_rst_n;
  acsp_ser_state_t state_r;
  acsp_ser_state_t state_nxt;
  logic [2:0] bit_cnt_r;
  logic [6:0] sh_r;
  logic [7:0] byte_in;
  logic rd_r;
  logic rd_nxt;
  logic [ADDR_W-1:0] left_r;
  logic [ADDR_W-1:0] left_nxt;
  logic post_vld;
  acsp_evt_t post_kind;
  logic [7:0] post_byte;
  logic evt_tgl_r;
  acsp_evt_t evt_kind_r;
  logic [7:0] evt_byte_r;
  logic sfall_tgl_r;
  logic cont_s;

  // Master clock side state
  logic evt_tgl_s;
  logic evt_seen_r;
  logic evt_stb;
  logic sfall_tgl_s;
  logic sfall_seen_r;
  logic sfall_stb;
  logic sys_hit;
  logic single_hit;
  logic sys_p_r [SYS_N];
  logic cont_r;
  logic conv_done_n_r;
  logic [FRAME_W-1:0] new_frame;
  logic [FRAME_W-1:0] latest_r;
  logic [FRAME_W-1:0] out_frame_r;
  logic [ADDR_W-1:0] reg_addr_r;
  logic [7:0] reg_wdata_r;
  logic reg_we_r;
  logic [7:0] rd_byte_r;

  // Chip select high holds the link-side shifters and byte framing in reset; event and edge toggles are not reset, but only the edge toggle keeps running
  assign ser_rst_n = NRST & ~CS_N;

  assign byte_in = {sh_r, DIN};

  // Input shifter on falling edges
  always_ff @(negedge SCLK or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      bit_cnt_r <= 3'h0;
      sh_r <= 7'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r <= byte_in[6:0];
    end
  end

  // Byte framing; every byte is decoded, even while data shifts out
  always_comb begin
    state_nxt = state_r;
    rd_nxt = rd_r;
    left_nxt = left_r;
    post_vld = 1'b0;
    post_kind = EV_SYS;
    post_byte = byte_in;
    if (bit_cnt_r == BIT_EARLY && state_r == S_CMD && is_early(byte_in[6:0])) begin
      post_vld = 1'b1;
      post_byte = {byte_in[6:0], 1'b0};
    end else if (bit_cnt_r == BIT_LAST) begin
      unique case (state_r)
        S_CMD: begin
          if (byte_in == OP_CONT_ON || byte_in == OP_CONT_OFF) begin
            post_vld = 1'b1;
          end else if (byte_in[7:5] == OP_REGISTER_READ_CMD_HI && !cont_s) begin
            post_vld = 1'b1;
            post_kind = EV_REGISTER_READ_CMD;
            rd_nxt = 1'b1;
            state_nxt = S_CNT;
          end else if (byte_in[7:5] == OP_REGISTER_WRITE_CMD_HI) begin
            post_vld = 1'b1;
            post_kind = EV_REGISTER_WRITE_CMD;
            rd_nxt = 1'b0;
            state_nxt = S_CNT;
          end
        end
        S_CNT: begin
          left_nxt = byte_in[ADDR_W-1:0];
          if (byte_in[7:5] != OP_CNT_HI) begin
            state_nxt = S_CMD;
          end else if (rd_r) begin
            state_nxt = S_RDATA;
          end else begin
            state_nxt = S_WDATA;
          end
        end
        S_WDATA: begin
          post_vld = 1'b1;
          post_kind = EV_WDATA;
          left_nxt = left_r - 5'h01;
          if (left_r == 5'h00) begin
            state_nxt = S_CMD;
          end
        end
        S_RDATA: begin
          post_vld = 1'b1;
          post_kind = EV_RNEXT;
          left_nxt = left_r - 5'h01;
          if (left_r == 5'h00) begin
            state_nxt = S_CMD;
          end
        end
      endcase
    end
  end

  always_ff @(negedge SCLK or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      state_r <= S_CMD;
      rd_r <= 1'b0;
      left_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      rd_r <= rd_nxt;
      left_r <= left_nxt;
    end
  end

  // Event word held stable until the next byte; a toggle marks it.
  // Not reset by chip select, or raising it would fake an event.
  always_ff @(negedge SCLK or negedge NRST) begin
    if (!NRST) begin
      evt_tgl_r <= 1'b0;
      evt_kind_r <= EV_SYS;
      evt_byte_r <= 8'h00;
    end else if (post_vld) begin
      evt_tgl_r <= ~evt_tgl_r;
      evt_kind_r <= post_kind;
      evt_byte_r <= post_byte;
    end
  end

  // Every falling edge counts, selected or not
  always_ff @(negedge SCLK or negedge NRST) begin
    if (!NRST) begin
      sfall_tgl_r <= 1'b0;
    end else begin
      sfall_tgl_r <= ~sfall_tgl_r;
    end
  end

  // Mode only changes between bytes, so two link edges settle it in time
  acsp_sync2 #(.RST_VAL(1'b1)) u_cont_sync (
    .clk(SCLK),
    .rst_n(NRST),
    .d(cont_r),
    .q(cont_s)
  );

  acsp_sync2 #(.RST_VAL(1'b0)) u_evt_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .d(evt_tgl_r),
    .q(evt_tgl_s)
  );

  acsp_sync2 #(.RST_VAL(1'b0)) u_sfall_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .d(sfall_tgl_r),
    .q(sfall_tgl_s)
  );

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      evt_seen_r <= 1'b0;
      sfall_seen_r <= 1'b0;
    end else begin
      evt_seen_r <= evt_tgl_s;
      sfall_seen_r <= sfall_tgl_s;
    end
  end

  assign evt_stb = evt_tgl_s ^ evt_seen_r;
  assign sfall_stb = sfall_tgl_s ^ sfall_seen_r;
  assign sys_hit = evt_stb && evt_kind_r == EV_SYS;
  assign single_hit = sys_hit && evt_byte_r == OP_SINGLE;

  // One pulse output per system command
  for (genvar g = 0; g < SYS_N; g++) begin : g_sys
    always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
        sys_p_r[g] <= 1'b0;
      end else begin
        sys_p_r[g] <= sys_hit && evt_byte_r == SYS_OPS[g];
      end
    end
    assign SYS_CMD_P[g] = sys_p_r[g];
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cont_r <= 1'b1;
    end else if (sys_hit && evt_byte_r == OP_CONT_ON) begin
      cont_r <= 1'b1;
    end else if (sys_hit && evt_byte_r == OP_CONT_OFF) begin
      cont_r <= 1'b0;
    end
  end

  // A new result wins over a same-cycle serial edge; chip select plays no part
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      conv_done_n_r <= 1'b1;
    end else if (RESULT_STB) begin
      conv_done_n_r <= 1'b0;
    end else if (sfall_stb) begin
      conv_done_n_r <= 1'b1;
    end
  end

  assign new_frame = {STATUS_PREFIX, STATUS_BITS, CH_RESULTS};

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      latest_r <= '0;
    end else if (RESULT_STB) begin
      latest_r <= new_frame;
    end
  end

  // Outside continuous read the frame only moves on a single-read command,
  // so a readback may overlap the next result without tearing
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      out_frame_r <= '0;
    end else if (single_hit) begin
      out_frame_r <= RESULT_STB ? new_frame : latest_r;
    end else if (RESULT_STB && cont_r) begin
      out_frame_r <= new_frame;
    end
  end

  // Register file address walks one step per data byte
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      reg_addr_r <= 5'h00;
    end else if (evt_stb && (evt_kind_r == EV_REGISTER_READ_CMD || evt_kind_r == EV_REGISTER_WRITE_CMD)) begin
      reg_addr_r <= evt_byte_r[ADDR_W-1:0];
    end else if (reg_we_r || (evt_stb && evt_kind_r == EV_RNEXT)) begin
      reg_addr_r <= reg_addr_r + 5'h01;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      reg_we_r <= 1'b0;
      reg_wdata_r <= 8'h00;
    end else begin
      reg_we_r <= evt_stb && evt_kind_r == EV_WDATA;
      if (evt_stb && evt_kind_r == EV_WDATA) begin
        reg_wdata_r <= evt_byte_r;
      end
    end
  end

  // Read byte is re-registered every cycle; the link reads it bit by bit as it shifts out
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rd_byte_r <= 8'h00;
    end else begin
      rd_byte_r <= REG_RDATA;
    end
  end

  // Frame and read byte are quasi-static: the host keeps off the link
  // for a few master clocks around each change
  assign lnk.frame = out_frame_r;
  assign lnk.rd_byte = rd_byte_r;
  assign lnk.reg_mode = (state_r == S_RDATA);

  acsp_shift_out u_shift (
    .sclk(SCLK),
    .ser_rst_n(ser_rst_n),
    .lnk(lnk.shifter)
  );

  assign DOUT = lnk.dout;
  assign DOUT_OE = lnk.dout_oe;
  assign CONV_DONE_N = conv_done_n_r;
  assign CONT_READ = cont_r;
  assign REG_ADDR = reg_addr_r;
  assign REG_WDATA = reg_wdata_r;
  assign REG_WE = reg_we_r;

  sequence s_sys_evt(logic [7:0] op);
    evt_stb && evt_kind_r == EV_SYS && evt_byte_r == op;
  endsequence

  property p_hiz;
    @(posedge CLK_SYS) disable iff (!NRST)
      CS_N |-> !DOUT_OE;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("serial output driven while deselected");

  property p_result_low;
    @(posedge CLK_SYS) disable iff (!NRST)
      RESULT_STB |=> !CONV_DONE_N;
  endproperty
  a_result_low: assert property (p_result_low)
    else $error("conversion-done did not fall on a new result");

  property p_fall_rise_deselected;
    @(posedge CLK_SYS) disable iff (!NRST)
      (CS_N && sfall_stb && !RESULT_STB) |=> CONV_DONE_N;
  endproperty
  a_fall_rise_deselected: assert property (p_fall_rise_deselected)
    else $error("conversion-done not released by a deselected serial edge");

  // A link falling edge followed by two cycles with no new result
  sequence s_quiet_fall;
    ($changed(sfall_tgl_r) && !RESULT_STB) ##1 !RESULT_STB [*2];
  endsequence

  property p_fall_rise;
    @(posedge CLK_SYS) disable iff (!NRST)
      s_quiet_fall |-> ##[SYNC_MIN:SYNC_MAX] CONV_DONE_N;
  endproperty
  a_fall_rise: assert property (p_fall_rise)
    else $error("conversion-done not high after a serial falling edge");

  property p_evt_cross;
    @(posedge CLK_SYS) disable iff (!NRST)
      $changed(evt_tgl_r) |-> ##[SYNC_MIN:SYNC_MAX] evt_stb;
  endproperty
  a_evt_cross: assert property (p_evt_cross)
    else $error("command event lost in the clock crossing");

  property p_start_pulse;
    @(posedge CLK_SYS) disable iff (!NRST)
      s_sys_evt(OP_START) |=> SYS_CMD_P[SYS_START] ##1 !SYS_CMD_P[SYS_START];
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start command did not give a single pulse");

  property p_reset_pulse;
    @(posedge CLK_SYS) disable iff (!NRST)
      s_sys_evt(OP_RESET) |=> SYS_CMD_P[SYS_RESET] && !SYS_CMD_P[SYS_WAKEUP];
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset command decoded wrongly");

  property p_cont_off;
    @(posedge CLK_SYS) disable iff (!NRST)
      s_sys_evt(OP_CONT_OFF) |=> !CONT_READ;
  endproperty
  a_cont_off: assert property (p_cont_off)
    else $error("continuous read not left");

  property p_single_load;
    @(posedge CLK_SYS) disable iff (!NRST)
      (single_hit && !RESULT_STB) |=> (out_frame_r == $past(latest_r));
  endproperty
  a_single_load: assert property (p_single_load)
    else $error("single read did not load the latest result");

  property p_early_decode;
    @(negedge SCLK) disable iff (!ser_rst_n)
      (bit_cnt_r == BIT_EARLY && state_r == S_CMD && is_early(byte_in[6:0]))
        |=> (evt_tgl_r != $past(evt_tgl_r));
  endproperty
  a_early_decode: assert property (p_early_decode)
    else $error("short command not posted on the seventh edge");

  property p_register_read_cmd_ignored;
    @(negedge SCLK) disable iff (!ser_rst_n)
      (bit_cnt_r == BIT_LAST && state_r == S_CMD && byte_in[7:5] == OP_REGISTER_READ_CMD_HI && cont_s)
        |=> (state_r == S_CMD);
  endproperty
  a_register_read_cmd_ignored: assert property (p_register_read_cmd_ignored)
    else $error("register read accepted during continuous read");

  property p_register_write_cmd_frame;
    @(negedge SCLK) disable iff (!ser_rst_n)
      (bit_cnt_r == BIT_LAST && state_r == S_CMD && byte_in[7:5] == OP_REGISTER_WRITE_CMD_HI)
        |=> (state_r == S_CNT && !rd_r);
  endproperty
  a_register_write_cmd_frame: assert property (p_register_write_cmd_frame)
    else $error("register write did not expect a count byte");
endmodule : acsp_port
`default_nettype wire

// File: inc/acsp_pkg.sv
// Constants, types and decode helpers of the converter serial command port
`default_nettype none
package acsp_pkg;
  // Read frame layout
  localparam int STATUS_W = 24;
  localparam int CH_W = 24;
  localparam int CH_N = 8;
  localparam int FRAME_W = STATUS_W + CH_W * CH_N;
  localparam int STATUS_FREE_W = STATUS_W - 4;
  localparam int RESULT_W = CH_W * CH_N;
  localparam logic [3:0] STATUS_PREFIX = 4'hc;
  localparam logic [7:0] FRAME_LAST = 8'(FRAME_W - 1);

  // Master clock period in ns, and host-side spacing in master clock periods
  localparam int MCLK_PERIOD_NS = 5;
  localparam int BYTE_DECODE_GAP_CLK = 4;
  localparam int CS_HOLD_CLK = 4;
  localparam int WAKE_GAP_CLK = 4;
  localparam int RESET_BUSY_CLK = 18;

  // Bit positions inside a command byte
  localparam logic [2:0] BIT_EARLY = 3'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int ADDR_W = 5;

  // Single-byte system commands, one output pulse each
  localparam int SYS_N = 5;
  localparam int SYS_WAKEUP = 0;
  localparam int SYS_STANDBY = 1;
  localparam int SYS_RESET = 2;
  localparam int SYS_START = 3;
  localparam int SYS_STOP = 4;
  localparam logic [7:0] OP_WAKEUP = 8'h02;
  localparam logic [7:0] OP_STANDBY = 8'h04;
  localparam logic [7:0] OP_RESET = 8'h06;
  localparam logic [7:0] OP_START = 8'h08;
  localparam logic [7:0] OP_STOP = 8'h0a;
  localparam logic [7:0] SYS_OPS [SYS_N] = '{OP_WAKEUP, OP_STANDBY, OP_RESET, OP_START, OP_STOP};

  // Data read commands and register access prefixes
  localparam logic [7:0] OP_CONT_ON = 8'h10;
  localparam logic [7:0] OP_CONT_OFF = 8'h11;
  localparam logic [7:0] OP_SINGLE = 8'h12;
  localparam logic [2:0] OP_REGISTER_READ_CMD_HI = 3'h1;
  localparam logic [2:0] OP_REGISTER_WRITE_CMD_HI = 3'h2;
  localparam logic [2:0] OP_CNT_HI = 3'h0;

  typedef enum logic [1:0] {
    S_CMD = 2'b00,
    S_CNT = 2'b01,
    S_WDATA = 2'b11,
    S_RDATA = 2'b10
  } acsp_ser_state_t;

  typedef enum logic [2:0] {
    EV_SYS = 3'h0,
    EV_REGISTER_READ_CMD = 3'h1,
    EV_REGISTER_WRITE_CMD = 3'h2,
    EV_WDATA = 3'h3,
    EV_RNEXT = 3'h4
  } acsp_evt_t;

  // True when the first seven bits already identify a command
  function automatic logic is_early(input logic [6:0] b7);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < SYS_N; i++) begin
      if (b7 == SYS_OPS[i][7:1]) begin
        hit = 1'b1;
      end
    end
    if (b7 == OP_SINGLE[7:1]) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_early
endpackage : acsp_pkg
`default_nettype wire

// File: inc/acsp_link_if.sv
// Carrier between the command core and the serial output shifter
`default_nettype none
interface acsp_link_if;
  import acsp_pkg::*;
  logic [FRAME_W-1:0] frame;
  logic [7:0] rd_byte;
  logic reg_mode;
  logic dout;
  logic dout_oe;
  modport core (output frame, output rd_byte, output reg_mode, input dout, input dout_oe);
  modport shifter (input frame, input rd_byte, input reg_mode, output dout, output dout_oe);
endinterface : acsp_link_if
`default_nettype wire

// File: hw/acsp_sync2.sv
// Two-flop level synchroniser
`default_nettype none
module acsp_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and synchronised level out
  input wire logic d,
  output logic q
);
  logic meta_r;

  // Only the second flop is ever read outside this module
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : acsp_sync2
`default_nettype wire

// File: hw/acsp_shift_out.sv
// Serial output shifter on the link clock
`default_nettype none
module acsp_shift_out
  import acsp_pkg::*;
(
  // Link clock and serial reset (low while chip select is high)
  input wire logic sclk,
  input wire logic ser_rst_n,
  // Paths to the core
  acsp_link_if.shifter lnk
);
  logic [7:0] idx_r;
  logic [2:0] bit_r;
  logic dout_r;
  logic oe_r;
  logic msb_w;

  assign msb_w = lnk.frame[FRAME_LAST];

  // Frame wraps to its first bit, so extra clocks repeat the readback
  always_ff @(posedge sclk or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      idx_r <= 8'h00;
      bit_r <= 3'h0;
      dout_r <= 1'b0;
    end else if (lnk.reg_mode) begin
      dout_r <= lnk.rd_byte[BIT_LAST - bit_r];
      bit_r <= bit_r + 3'h1;
    end else begin
      dout_r <= lnk.frame[FRAME_LAST - idx_r];
      idx_r <= (idx_r == FRAME_LAST) ? 8'h00 : idx_r + 8'h01;
      bit_r <= 3'h0;
    end
  end

  // Pin floats whenever chip select is high
  always_ff @(posedge sclk or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= 1'b1;
    end
  end

  assign lnk.dout = dout_r;
  assign lnk.dout_oe = oe_r;

  property p_frame_msb_first;
    @(posedge sclk) disable iff (!ser_rst_n)
      (!lnk.reg_mode && idx_r == 8'h00) |=> (lnk.dout == $past(msb_w));
  endproperty
  a_frame_msb_first: assert property (p_frame_msb_first)
    else $error("frame does not start with its most significant bit");

  property p_frame_wrap;
    @(posedge sclk) disable iff (!ser_rst_n)
      (!lnk.reg_mode && idx_r == FRAME_LAST) |=> (idx_r == 8'h00);
  endproperty
  a_frame_wrap: assert property (p_frame_wrap)
    else $error("frame readback does not wrap to the first bit");
endmodule : acsp_shift_out
`default_nettype wire

// File: sim/acsp_host.sv
// Serial master model for the converter command port
`default_nettype none
module acsp_host (
  // Serial pins toward the device
  output logic cs_n,
  output logic sclk,
  output logic din,
  // Serial pins from the device
  input wire logic dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Whole bytes only, 48 ns period; din moves 2 ns after the fall to stay clear of sampling
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #2 din = tx[i];
      #22 sclk = 1'b1;
      // A floating line reads as the inverse of its last value
      #24 rx[i] = dout_oe ? dout : ~dout;
      sclk = 1'b0;
    end
    #2 din = ~din;
    #58;
  endtask : xfer
  task automatic sel(input logic on);
    #30 cs_n = ~on;
    #30;
  endtask : sel
endmodule : acsp_host
`default_nettype wire

// File: sim/test_adc_serial_command_port.sv
// Self-checking bench of the converter serial command port
`default_nettype none
module test_adc_serial_command_port
  import acsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic nrst;
  logic result_stb;
  logic [STATUS_FREE_W-1:0] status_bits;
  logic [RESULT_W-1:0] ch_results;
  logic [7:0] reg_rdata;
  logic cs_n, sclk, din, dout, dout_oe, conv_done_n, cont_read, reg_we;
  logic [SYS_N-1:0] sys_cmd_p;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_sys [SYS_N];
  int n_exp [SYS_N];
  int n_sum;
  int k;
  logic [12:0] wq [$];
  logic [FRAME_W-1:0] f1, f2;
  logic [7:0] rx, d0, d1;
  logic [4:0] ra;

  // Register file behind the port: each address holds a fixed mix of itself
  function automatic logic [7:0] exp_reg(input logic [4:0] a);
    return {3'h5, a} ^ 8'h3c;
  endfunction : exp_reg
  // Byte b of a frame as the host reads it, wrapping after the last byte
  function automatic logic [7:0] frame_byte(input logic [FRAME_W-1:0] f, input int b);
    return f[FRAME_W-1-8*(b%(FRAME_W/8)) -: 8];
  endfunction : frame_byte
  assign reg_rdata = exp_reg(reg_addr);

  acsp_port acsp_port_i (.CLK_SYS(clk), .NRST(nrst), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .DOUT(dout), .DOUT_OE(dout_oe), .CONV_DONE_N(conv_done_n), .RESULT_STB(result_stb),
    .STATUS_BITS(status_bits), .CH_RESULTS(ch_results), .SYS_CMD_P(sys_cmd_p),
    .CONT_READ(cont_read), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we),
    .REG_RDATA(reg_rdata));
  acsp_host acsp_host_i (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    for (int i = 0; i < SYS_N; i++) begin
      if (sys_cmd_p[i] === 1'b1) n_sys[i]++;
    end
    if (reg_we === 1'b1) wq.push_back({reg_addr, reg_wdata});
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // New result with the link idle, kept clear of serial clocks on both sides
  task automatic strobe(output logic [FRAME_W-1:0] f);
    @(posedge clk);
    #1 status_bits = STATUS_FREE_W'($urandom());
    for (int i = 0; i < CH_N; i++) ch_results[i*CH_W +: CH_W] = CH_W'($urandom());
    result_stb = 1'b1;
    f = {STATUS_PREFIX, status_bits, ch_results};
    @(posedge clk);
    #1 result_stb = 1'b0;
    @(posedge clk);
    #1 check("conv_done_n", conv_done_n, 0);
    repeat (5) @(posedge clk);
  endtask : strobe
  // One frame plus one byte, showing the wrap to the first byte
  task automatic read_frame(input logic [FRAME_W-1:0] f);
    acsp_host_i.sel(1);
    for (int b = 0; b <= FRAME_W / 8; b++) begin
      acsp_host_i.xfer(8'h00, rx);
      check("frame", rx, frame_byte(f, b));
      if (b == 0) check("conv_done_n", conv_done_n, 1);
    end
    acsp_host_i.sel(0);
  endtask : read_frame
  task automatic cmd(input logic [7:0] op);
    acsp_host_i.sel(1);
    acsp_host_i.xfer(op, rx);
    acsp_host_i.sel(0);
  endtask : cmd

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    result_stb = 1'b0;
    status_bits = '0;
    ch_results = '0;
    for (int i = 0; i < SYS_N; i++) begin
      n_sys[i] = 0;
      n_exp[i] = 0;
    end
    void'($urandom(32'hefaab1cb));
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    check("cont_read", cont_read, 1);
    check("dout_oe", dout_oe, 0);
    check("conv_done_n", conv_done_n, 1);
    strobe(f1);
    // Clocks with select high must lift done but run no command
    acsp_host_i.xfer(OP_START, rx);
    check("conv_done_n", conv_done_n, 1);
    check("start count", n_sys[SYS_START], 0);
    check("dout_oe", dout_oe, 0);
    strobe(f1);
    read_frame(f1);
    cmd(OP_CONT_OFF);
    check("cont_read", cont_read, 0);
    for (int i = 0; i < SYS_N; i++) begin
      cmd(SYS_OPS[i]);
      n_exp[i]++;
      #100;
      check("sys count", n_sys[i], n_exp[i]);
    end
    // Random order next; an unknown opcode must pulse nothing
    for (int j = 0; j < 4; j++) begin
      k = $urandom_range(0, SYS_N - 1);
      cmd(SYS_OPS[k]);
      n_exp[k]++;
      #100;
    end
    cmd(8'h0c);
    #100;
    n_sum = 0;
    for (int i = 0; i < SYS_N; i++) begin
      check("sys count", n_sys[i], n_exp[i]);
      n_sum += n_sys[i];
    end
    check("sys sum", n_sum, SYS_N + 4);
    // Outside continuous read only the single-read command reloads the frame
    strobe(f2);
    read_frame(f1);
    cmd(OP_SINGLE);
    read_frame(f2);
    ra = 5'($urandom_range(0, 29));
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    acsp_host_i.sel(1);
    acsp_host_i.xfer({OP_REGISTER_WRITE_CMD_HI, ra}, rx);
    acsp_host_i.xfer({OP_CNT_HI, 5'h01}, rx);
    acsp_host_i.xfer(d0, rx);
    acsp_host_i.xfer(d1, rx);
    acsp_host_i.sel(0);
    check("writes", wq.size(), 2);
    check("write 0", wq[0], {ra, d0});
    check("write 1", wq[1], {ra + 5'h01, d1});
    acsp_host_i.sel(1);
    acsp_host_i.xfer({OP_REGISTER_READ_CMD_HI, ra}, rx);
    acsp_host_i.xfer({OP_CNT_HI, 5'h01}, rx);
    acsp_host_i.xfer(8'h00, rx);
    check("read 0", rx, exp_reg(ra));
    acsp_host_i.xfer(8'h00, rx);
    check("read 1", rx, exp_reg(ra + 5'h01));
    acsp_host_i.sel(0);
    cmd(OP_CONT_ON);
    check("cont_read", cont_read, 1);
    // Ignored register read: its count slot is taken as a command
    acsp_host_i.sel(1);
    acsp_host_i.xfer({OP_REGISTER_READ_CMD_HI, ra}, rx);
    acsp_host_i.xfer(OP_CONT_OFF, rx);
    acsp_host_i.sel(0);
    check("cont_read", cont_read, 0);
    final_report();
  end
endmodule : test_adc_serial_command_port
`default_nettype wire
